// >>> shared/sgps_defs.svh
/*
  Constants of the switchgear position supervisor: register offsets, field
  positions, reset values and timing figures.
  Assumes a 50 MHz system clock and a word-aligned plain register port.
*/
// Overview of operation
// - Separate close and open travel times held
// - Close command limited, cut at closed
// - Open command limited, cut at open
// - Close command starts timer, shows intermediate if closed contact wired
// - Feedback before expiry gives closed/open
// - Timer expiry without feedback gives faulty
// - Open command starts timer, shows intermediate if open contact wired
// - Position from contacts plus timer state
// - Code intermediate 0, open 1, closed 2, faulty 3
// - Contacts opposite give open or closed
// - Contacts equal: intermediate, then faulty
// - One contact wired sets single flag
// - Single contact supervises its own direction
// - Closed-only: close timed, success on closed
// - Single contact expiry gives faulty
// - Optional dwell shows intermediate, then end
// - No contact assigned gives faulty
// - Open-only: open timed, success on open
`ifndef SGPS_DEFS_SVH
`define SGPS_DEFS_SVH

`define SGPS_CLK_KHZ        50000
`define SGPS_TRAVEL_DEF_MS  100
`define SGPS_DWELL_DEF_MS   0

`define SGPS_ADDR_W         8
`define SGPS_OFS_CLOSE_T    8'h00
`define SGPS_OFS_OPEN_T     8'h04
`define SGPS_OFS_DWELL_T    8'h08
`define SGPS_OFS_CFG        8'h0C
`define SGPS_OFS_CMD        8'h10
`define SGPS_OFS_STAT       8'h14

`define SGPS_CFG_CLOSED_W   0
`define SGPS_CFG_OPEN_W     1
`define SGPS_CFG_RST        2'h3

`define SGPS_CMD_CLOSE      0
`define SGPS_CMD_OPEN       1

`define SGPS_ST_CODE        0
`define SGPS_ST_SINGLE      2
`define SGPS_ST_SUCCESS     3
`define SGPS_ST_CLOSE_CMD   4
`define SGPS_ST_OPEN_CMD    5
`define SGPS_ST_STATE       6

`endif

// >>> shared/sgps_pkg.sv
/*
  Types of the switchgear position supervisor: supervision states and the
  2-bit position code.
  Assumes the constants header is compiled alongside.
*/
package sgps_pkg;

  // Gray along idle -> move -> dwell; dwell -> idle flips both bits
  typedef enum logic [1:0] {
    SGPS_IDLE  = 2'h0,
    SGPS_MOVE  = 2'h1,
    SGPS_DWELL = 2'h3
  } sgps_state_t;

  typedef enum logic [1:0] {
    SGPS_POS_INTERM = 2'h0,
    SGPS_POS_OPEN   = 2'h1,
    SGPS_POS_CLOSED = 2'h2,
    SGPS_POS_FAULTY = 2'h3
  } sgps_pos_t;

endpackage

// >>> hdl/sgps_sync.sv
/*
  Three-stage synchroniser for the auxiliary contact pins with a two-stage
  agreement filter.
  Assumes asynchronous pin inputs and the single system clock.
*/
`timescale 1ns/1ps
`default_nettype none

module sgps_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,    // System clock
  input  wire logic         rst_n,  // Synchronous reset, active low
  input  wire logic [W-1:0] din,    // Raw pin levels
  output logic      [W-1:0] dout    // Filtered levels
);

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;
  logic [W-1:0] stage3_r;

  // A level change is taken only once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
      dout     <= '0;
    end else begin
      stage1_r <= din;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      for (int i = 0; i < W; i++) begin
        if (stage2_r[i] == stage3_r[i]) begin
          dout[i] <= stage3_r[i];
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> hdl/sgps_timer.sv
/*
  Travel and dwell tick counter. A start loads the first tick, each
  running cycle before expiry adds one, and expiry is a level once the limit is met.
  Assumes limit is stable while the counter runs.
*/
`timescale 1ns/1ps
`default_nettype none

module sgps_timer #(
  parameter int W = 32
) (
  input  wire logic         clk,      // System clock
  input  wire logic         rst_n,    // Synchronous reset, active low
  input  wire logic         start,    // Restart from the first tick
  input  wire logic         run,      // Count this cycle
  input  wire logic [W-1:0] limit,    // Terminal tick count
  output logic              expired,  // Limit reached
  output logic      [W-1:0] count     // Ticks counted so far
);

  logic [W-1:0] count_r;

  assign expired = (count_r >= limit);
  assign count   = count_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (start) begin
      count_r <= W'(1);
    end else if (run && !expired) begin
      count_r <= count_r + W'(1);
    end
  end

  a_timer_restart: assert property (@(posedge clk) disable iff (!rst_n)
    start |=> (count_r == W'(1)))
    else $error("timer not restarted by a new command");

endmodule

`default_nettype wire

// >>> hdl/sgps_top.sv
/*
  Switchgear position supervisor for one unit: validates the closed and open
  auxiliary contacts against close, open and dwell timers, drives the close
  and open command outputs and reports the position code.
  Assumes contacts arrive asynchronously on pins and software drives the
  plain register port on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sgps_defs.svh"

module sgps_top #(
  parameter int          TW            = 32,
  parameter logic [31:0] CLOSE_T_RESET = 32'(`SGPS_TRAVEL_DEF_MS * `SGPS_CLK_KHZ),
  parameter logic [31:0] OPEN_T_RESET  = 32'(`SGPS_TRAVEL_DEF_MS * `SGPS_CLK_KHZ),
  parameter logic [31:0] DWELL_T_RESET = 32'(`SGPS_DWELL_DEF_MS * `SGPS_CLK_KHZ)
) (
  input  wire logic                    clk,              // System clock, 50 MHz
  input  wire logic                    rst_n,            // Synchronous reset, active low
  input  wire logic [`SGPS_ADDR_W-1:0] regAddr,          // Register byte address
  input  wire logic [31:0]             regWrData,        // Write data
  input  wire logic                    regWr,            // Write strobe
  input  wire logic                    regRd,            // Read strobe
  output logic      [31:0]             regRdData,        // Read data, cycle after strobe
  input  wire logic                    auxClosedPin,     // Closed auxiliary contact
  input  wire logic                    auxOpenPin,       // Open auxiliary contact
  output logic                         closeCmd,         // Close relay drive
  output logic                         openCmd,          // Open relay drive
  output sgps_pkg::sgps_pos_t          posCode,          // Position code
  output logic                         posClosed,        // Closed indication
  output logic                         posOpen,          // Open indication
  output logic                         posInterm,        // Intermediate indication
  output logic                         posFaulty,        // Faulty indication
  output logic                         oneContactFlag,   // Only one contact wired
  output logic                         switchingSuccess  // Last supervised move succeeded
);
  import sgps_pkg::*;

  logic [TW-1:0] closeTime_r;
  logic [TW-1:0] openTime_r;
  logic [TW-1:0] dwellTime_r;
  logic          cfgClosedW_r;
  logic          cfgOpenW_r;
  sgps_state_t   state_r;
  sgps_state_t   state_nxt;
  logic          dirClose_r;
  logic          dirClose_nxt;
  logic          faultLatch_r;
  logic          faultLatch_nxt;
  logic          assumeLatch_r;
  logic          assumeLatch_nxt;
  logic          success_r;
  logic          success_nxt;
  sgps_pos_t     pos_r;
  sgps_pos_t     pos_nxt;
  logic          closeCmd_r;
  logic          openCmd_r;
  logic          single_r;
  logic [31:0]   rdData_r;
  logic [TW-1:0] cmdAge_r;

  // Contact inputs, filtered
  logic [1:0] auxSync;
  wire        cSt = auxSync[0];
  wire        oSt = auxSync[1];

  sgps_sync #(
    .W    (2)
  ) u_sync (
    .clk  (clk),
    .rst_n(rst_n),
    .din  ({auxOpenPin, auxClosedPin}),
    .dout (auxSync)
  );

  // Register port decode
  wire selCloseT = (regAddr == `SGPS_OFS_CLOSE_T);
  wire selOpenT  = (regAddr == `SGPS_OFS_OPEN_T);
  wire selDwellT = (regAddr == `SGPS_OFS_DWELL_T);
  wire selCfg    = (regAddr == `SGPS_OFS_CFG);
  wire selCmd    = (regAddr == `SGPS_OFS_CMD);
  wire selStat   = (regAddr == `SGPS_OFS_STAT);

  // Open has priority when both command bits are written at once
  wire cmdOpen  = regWrData[`SGPS_CMD_OPEN];
  wire cmdClose = regWrData[`SGPS_CMD_CLOSE];
  wire cmdWrite = regWr && selCmd && (cmdOpen || cmdClose);

  // Wiring modes
  wire bothWired   = cfgClosedW_r && cfgOpenW_r;
  wire singleWired = cfgClosedW_r ^ cfgOpenW_r;
  wire wiredVal    = cfgClosedW_r ? cSt : oSt;
  wire sgps_pos_t wiredPos = cfgClosedW_r ? SGPS_POS_CLOSED : SGPS_POS_OPEN;
  wire sgps_pos_t otherPos = cfgClosedW_r ? SGPS_POS_OPEN : SGPS_POS_CLOSED;

  // Only the direction whose contact is wired is supervised
  wire supervised = dirClose_r ? cfgClosedW_r : cfgOpenW_r;

  function automatic logic reached(input logic dirC, input logic c, input logic o,
                                   input logic wC, input logic wO);
    if (dirC) begin
      reached = wC && c && (!wO || !o);
    end else begin
      reached = wO && o && (!wC || !c);
    end
  endfunction

  wire targetSeen = reached(dirClose_r, cSt, oSt, cfgClosedW_r, cfgOpenW_r);

  // Shared timer: travel limit while moving, dwell limit while dwelling
  logic          timerStart;
  logic          timerExp;
  logic [TW-1:0] timerCount;
  wire  [TW-1:0] travelLimit = dirClose_r ? closeTime_r : openTime_r;
  wire  [TW-1:0] timerLimit  = (state_r == SGPS_DWELL) ? dwellTime_r : travelLimit;
  wire           dwellSet    = (dwellTime_r != '0);

  sgps_timer #(
    .W      (TW)
  ) u_timer (
    .clk    (clk),
    .rst_n  (rst_n),
    .start  (timerStart),
    .run    (state_r != SGPS_IDLE),
    .limit  (timerLimit),
    .expired(timerExp),
    .count  (timerCount)
  );

  // Supervision sequence
  always_comb begin
    state_nxt       = state_r;
    dirClose_nxt    = dirClose_r;
    timerStart      = 1'b0;
    faultLatch_nxt  = faultLatch_r && !wiredVal;
    assumeLatch_nxt = assumeLatch_r && !wiredVal;
    success_nxt     = success_r;
    case (state_r)
      SGPS_IDLE: begin
        state_nxt = SGPS_IDLE;
      end
      SGPS_MOVE: begin
        if (targetSeen) begin
          state_nxt   = SGPS_IDLE;
          success_nxt = supervised;
        end else if (timerExp) begin
          if (singleWired && supervised && dwellSet) begin
            state_nxt  = SGPS_DWELL;
            timerStart = 1'b1;
          end else begin
            state_nxt      = SGPS_IDLE;
            faultLatch_nxt = singleWired && supervised;
          end
        end
      end
      SGPS_DWELL: begin
        if (targetSeen) begin
          state_nxt   = SGPS_IDLE;
          success_nxt = 1'b1;
        end else if (timerExp) begin
          state_nxt       = SGPS_IDLE;
          assumeLatch_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = SGPS_IDLE;
      end
    endcase
    // A new command restarts supervision from scratch
    if (cmdWrite) begin
      state_nxt       = SGPS_MOVE;
      dirClose_nxt    = !cmdOpen;
      timerStart      = 1'b1;
      faultLatch_nxt  = 1'b0;
      assumeLatch_nxt = 1'b0;
      success_nxt     = 1'b0;
    end
  end

  // Position evaluation from contacts and timer state
  always_comb begin
    pos_nxt = SGPS_POS_FAULTY;
    if (!cfgClosedW_r && !cfgOpenW_r) begin
      pos_nxt = SGPS_POS_FAULTY;
    end else if (bothWired) begin
      if (cSt && !oSt) begin
        pos_nxt = SGPS_POS_CLOSED;
      end else if (!cSt && oSt) begin
        pos_nxt = SGPS_POS_OPEN;
      end else if (state_r == SGPS_MOVE && !timerExp) begin
        pos_nxt = SGPS_POS_INTERM;
      end else begin
        pos_nxt = SGPS_POS_FAULTY;
      end
    end else if (state_r == SGPS_MOVE && supervised) begin
      pos_nxt = wiredVal ? wiredPos : SGPS_POS_INTERM;
    end else if (state_r == SGPS_DWELL) begin
      pos_nxt = SGPS_POS_INTERM;
    end else if (faultLatch_r) begin
      pos_nxt = SGPS_POS_FAULTY;
    end else if (assumeLatch_r) begin
      pos_nxt = wiredPos;
    end else begin
      pos_nxt = wiredVal ? wiredPos : otherPos;
    end
  end

  // Relay drive lasts as long as the move; a reached end drops it at once
  wire closeCmd_nxt = (state_nxt == SGPS_MOVE) && dirClose_nxt;
  wire openCmd_nxt  = (state_nxt == SGPS_MOVE) && !dirClose_nxt;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r       <= SGPS_IDLE;
      dirClose_r    <= 1'b0;
      faultLatch_r  <= 1'b0;
      assumeLatch_r <= 1'b0;
      success_r     <= 1'b0;
      pos_r         <= SGPS_POS_INTERM;
      closeCmd_r    <= 1'b0;
      openCmd_r     <= 1'b0;
      single_r      <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      dirClose_r    <= dirClose_nxt;
      faultLatch_r  <= faultLatch_nxt;
      assumeLatch_r <= assumeLatch_nxt;
      success_r     <= success_nxt;
      pos_r         <= pos_nxt;
      closeCmd_r    <= closeCmd_nxt;
      openCmd_r     <= openCmd_nxt;
      single_r      <= singleWired;
    end
  end

  // Settings registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      closeTime_r  <= TW'(CLOSE_T_RESET);
      openTime_r   <= TW'(OPEN_T_RESET);
      dwellTime_r  <= TW'(DWELL_T_RESET);
      cfgClosedW_r <= 1'(`SGPS_CFG_RST >> `SGPS_CFG_CLOSED_W);
      cfgOpenW_r   <= 1'(`SGPS_CFG_RST >> `SGPS_CFG_OPEN_W);
    end else if (regWr) begin
      if (selCloseT) begin
        closeTime_r <= regWrData[TW-1:0];
      end
      if (selOpenT) begin
        openTime_r <= regWrData[TW-1:0];
      end
      if (selDwellT) begin
        dwellTime_r <= regWrData[TW-1:0];
      end
      if (selCfg) begin
        cfgClosedW_r <= regWrData[`SGPS_CFG_CLOSED_W];
        cfgOpenW_r   <= regWrData[`SGPS_CFG_OPEN_W];
      end
    end
  end

  // Read path; unmapped addresses and the command word read as zero
  wire [31:0] statWord = {24'h00_0000, state_r, openCmd_r, closeCmd_r,
                          success_r, single_r, pos_r};
  wire [31:0] rdSel =
    selCloseT ? 32'(closeTime_r) :
    selOpenT  ? 32'(openTime_r)  :
    selDwellT ? 32'(dwellTime_r) :
    selCfg    ? {30'h0000_0000, cfgOpenW_r, cfgClosedW_r} :
    selStat   ? statWord : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdData_r <= 32'h0000_0000;
    end else begin
      rdData_r <= regRd ? rdSel : 32'h0000_0000;
    end
  end

  assign regRdData        = rdData_r;
  assign closeCmd         = closeCmd_r;
  assign openCmd          = openCmd_r;
  assign posCode          = pos_r;
  assign posClosed        = (pos_r == SGPS_POS_CLOSED);
  assign posOpen          = (pos_r == SGPS_POS_OPEN);
  assign posInterm        = (pos_r == SGPS_POS_INTERM);
  assign posFaulty        = (pos_r == SGPS_POS_FAULTY);
  assign oneContactFlag   = single_r;
  assign switchingSuccess = success_r;

  // Helper: cycles the close relay has been driven in the current move
  always_ff @(posedge clk) begin
    if (!rst_n || cmdWrite || !closeCmd_r) begin
      cmdAge_r <= '0;
    end else begin
      cmdAge_r <= cmdAge_r + TW'(1);
    end
  end

  a_close_cut_short: assert property (@(posedge clk) disable iff (!rst_n)
    (closeCmd_r && state_r == SGPS_MOVE && targetSeen && !cmdWrite) |=> !closeCmd_r)
    else $error("close drive not dropped at closed position");

  a_open_cut_short: assert property (@(posedge clk) disable iff (!rst_n)
    (openCmd_r && state_r == SGPS_MOVE && targetSeen && !cmdWrite) |=> !openCmd_r)
    else $error("open drive not dropped at open position");

  a_close_drive_bound: assert property (@(posedge clk) disable iff (!rst_n)
    (closeCmd_r && $stable(closeTime_r) && closeTime_r != '0) |-> (cmdAge_r < closeTime_r))
    else $error("close drive outlasted the close travel time");

  a_move_interm: assert property (@(posedge clk) disable iff (!rst_n)
    (bothWired && cmdWrite && !cmdOpen && closeTime_r > TW'(2))
      ##1 (cSt == oSt && !regWr) |=> posInterm)
    else $error("intermediate missing while travel timer runs");

  a_code_open: assert property (@(posedge clk) disable iff (!rst_n)
    (bothWired && !cSt && oSt && !(regWr && selCfg)) |=> (pos_r == SGPS_POS_OPEN))
    else $error("open contacts did not give code 1");

  a_code_closed: assert property (@(posedge clk) disable iff (!rst_n)
    (bothWired && cSt && !oSt && !(regWr && selCfg)) |=> (pos_r == SGPS_POS_CLOSED))
    else $error("closed contacts did not give code 2");

  a_equal_faulty: assert property (@(posedge clk) disable iff (!rst_n)
    (bothWired && cSt == oSt && state_r == SGPS_IDLE && !(regWr && selCfg)) |=> posFaulty)
    else $error("equal contacts with no timer did not give faulty");

  a_single_flag: assert property (@(posedge clk) disable iff (!rst_n)
    $stable(singleWired) |-> (oneContactFlag == singleWired))
    else $error("single contact flag does not follow wiring");

  a_dwell_interm: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == SGPS_DWELL && !cmdWrite) |=> posInterm)
    else $error("dwell did not show intermediate");

  a_success_set: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == SGPS_MOVE && targetSeen && supervised && !cmdWrite) |=> switchingSuccess)
    else $error("success flag not set on reaching the end position");

endmodule

`default_nettype wire

// >>> bench/sgps_gear_model.sv
/*
  Behavioural switchgear: two auxiliary contacts answering the relay drives.
  Assumes relay drives change on the system clock; a travel takes LAG cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module sgps_gear_model #(
  parameter int LAG = 3
) (
  input  wire logic clk,           // System clock
  input  wire logic closeCmd,      // Close relay drive
  input  wire logic openCmd,       // Open relay drive
  input  wire logic respond,       // Gear completes its travel
  input  wire logic stuckBoth,     // Both contacts welded high
  output logic      auxClosedPin,  // Closed contact
  output logic      auxOpenPin     // Open contact
);
  logic       prevC = 1'b0;
  logic       prevO = 1'b0;
  logic       target = 1'b0;
  logic       moving = 1'b0;
  logic       closedR = 1'b0;
  logic       openR = 1'b0;
  logic [7:0] lagCnt = 8'h00;

  // Leaving an end position opens both contacts at once, as a real mechanism does
  always @(posedge clk) begin
    prevC <= closeCmd;
    prevO <= openCmd;
    if ((closeCmd && !prevC) || (openCmd && !prevO)) begin
      target  <= !openCmd;
      moving  <= 1'b1;
      lagCnt  <= 8'h00;
      closedR <= 1'b0;
      openR   <= 1'b0;
    end else if (moving && respond) begin
      lagCnt <= lagCnt + 8'h01;
      if (lagCnt == 8'(LAG - 1)) begin
        moving  <= 1'b0;
        closedR <= target;
        openR   <= !target;
      end
    end
  end

  assign auxClosedPin = stuckBoth | closedR;
  assign auxOpenPin   = stuckBoth | openR;
endmodule

`default_nettype wire

// >>> bench/sgps_top_tb_top.sv
/*
  Self-checking bench of the switchgear position supervisor.
  Assumes the gear model on the contacts and short travel times by parameter.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sgps_defs.svh"

module sgps_top_tb_top;
  import sgps_pkg::*;
  localparam int CT = 20;
  localparam int OT = 12;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0000_0000;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [31:0] regRdData;
  logic        auxClosedPin, auxOpenPin, closeCmd, openCmd;
  sgps_pos_t   posCode;
  logic        posClosed, posOpen, posInterm, posFaulty, oneContactFlag, switchingSuccess;
  logic        respond = 1'b1;
  logic        stuckBoth = 1'b0;
  int          errors = 0;
  int          n_tests = 0;

  always #10 clk = ~clk;

  sgps_top #(.CLOSE_T_RESET(32'h0000_0014), .OPEN_T_RESET(32'h0000_0014), .DWELL_T_RESET(32'h0000_0000)) dut_u (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .auxClosedPin(auxClosedPin), .auxOpenPin(auxOpenPin), .closeCmd(closeCmd),
    .openCmd(openCmd), .posCode(posCode), .posClosed(posClosed), .posOpen(posOpen), .posInterm(posInterm),
    .posFaulty(posFaulty), .oneContactFlag(oneContactFlag), .switchingSuccess(switchingSuccess));

  sgps_gear_model #(.LAG(3)) gear_u (
    .clk(clk), .closeCmd(closeCmd), .openCmd(openCmd), .respond(respond), .stuckBoth(stuckBoth),
    .auxClosedPin(auxClosedPin), .auxOpenPin(auxOpenPin));

  task automatic final_report;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_code(input sgps_pos_t got, input sgps_pos_t exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic cmd(input logic [1:0] c);
    reg_wr(`SGPS_OFS_CMD, {30'h0000_0000, c});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Bounded wait for a position code; running out ends the run
  task automatic wait_code(input sgps_pos_t c, input int lim);
    for (int i = 0; i < lim && posCode !== c; i++) settle(1);
    chk_code(posCode, c);
    if (posCode !== c) final_report();
  endtask

  task automatic sc_reset;
    logic [31:0] d;
    reg_rd(`SGPS_OFS_CFG, d);
    chk_word(d, 32'h0000_0003);
    reg_rd(`SGPS_OFS_CLOSE_T, d);
    chk_word(d, 32'h0000_0014);
    reg_rd(8'h18, d);
    chk_word(d, 32'h0000_0000);
    settle(6);
    chk_code(posCode, SGPS_POS_FAULTY);
    chk_bit(oneContactFlag, 1'b0);
  endtask

  task automatic sc_close_ok;
    logic [31:0] d;
    reg_wr(`SGPS_OFS_OPEN_T, 32'(OT));
    cmd(2'h1);
    settle(2);
    chk_bit(closeCmd, 1'b1);
    chk_code(posCode, SGPS_POS_INTERM);
    chk_bit(posInterm, 1'b1);
    wait_code(SGPS_POS_CLOSED, CT);
    settle(1);
    chk_bit(closeCmd, 1'b0);
    chk_bit(switchingSuccess, 1'b1);
    chk_bit(posClosed, 1'b1);
    reg_rd(`SGPS_OFS_STAT, d);
    chk_word(d, 32'h0000_000A);
  endtask

  // Open right behind close: the second command takes over
  task automatic sc_restart;
    cmd(2'h1);
    cmd(2'h2);
    // Closed contacts still count until the filtered levels have left the end position
    settle(6);
    chk_bit(openCmd, 1'b1);
    chk_bit(closeCmd, 1'b0);
    chk_code(posCode, SGPS_POS_INTERM);
    wait_code(SGPS_POS_OPEN, OT);
    settle(1);
    chk_bit(openCmd, 1'b0);
    chk_bit(posOpen, 1'b1);
  endtask

  task automatic sc_timeout;
    int n;
    stuckBoth <= 1'b1;
    respond   <= 1'b0;
    cmd(2'h1);
    #1;
    n = 0;
    for (int i = 0; i < 200; i++) begin
      if (closeCmd === 1'b1) n++;
      else if (n > 0) break;
      if (n == 8) chk_code(posCode, SGPS_POS_INTERM);
      settle(1);
    end
    chk_word(32'(n), 32'(CT));
    settle(2);
    chk_code(posCode, SGPS_POS_FAULTY);
    chk_bit(posFaulty, 1'b1);
    stuckBoth <= 1'b0;
  endtask

  task automatic sc_single_closed;
    reg_wr(`SGPS_OFS_CFG, 32'h0000_0001);
    respond <= 1'b1;
    settle(2);
    chk_bit(oneContactFlag, 1'b1);
    // Park the gear open first, so that the close below really travels
    cmd(2'h2);
    settle(16);
    cmd(2'h1);
    settle(2);
    chk_bit(posInterm, 1'b1);
    wait_code(SGPS_POS_CLOSED, CT);
    settle(1);
    chk_bit(switchingSuccess, 1'b1);
    chk_bit(posInterm, 1'b0);
    // A close onto closed contacts succeeds at once, so open before the timeout
    cmd(2'h2);
    settle(16);
    respond <= 1'b0;
    cmd(2'h1);
    settle(CT + 4);
    chk_code(posCode, SGPS_POS_FAULTY);
    chk_bit(posInterm, 1'b0);
    reg_wr(`SGPS_OFS_DWELL_T, 32'h0000_000A);
    cmd(2'h1);
    settle(CT + 4);
    chk_code(posCode, SGPS_POS_INTERM);
    wait_code(SGPS_POS_CLOSED, 12);
    cmd(2'h2);
    settle(6);
    chk_bit(posInterm, 1'b0);
  endtask

  task automatic sc_single_open;
    reg_wr(`SGPS_OFS_CFG, 32'h0000_0002);
    respond <= 1'b1;
    cmd(2'h2);
    settle(2);
    chk_bit(posInterm, 1'b1);
    wait_code(SGPS_POS_OPEN, OT);
    settle(1);
    chk_bit(switchingSuccess, 1'b1);
    cmd(2'h1);
    settle(8);
    chk_bit(posInterm, 1'b0);
    chk_code(posCode, SGPS_POS_CLOSED);
    reg_wr(`SGPS_OFS_CFG, 32'h0000_0000);
    settle(6);
    chk_code(posCode, SGPS_POS_FAULTY);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    sc_reset();
    sc_close_ok();
    sc_restart();
    sc_timeout();
    sc_single_closed();
    sc_single_open();
    final_report();
  end
endmodule

`default_nettype wire
